//--- verilog/bdp_event_counter.sv
`timescale 1ns/1ps

module bdp_event_counter
    import bdp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Avalon-MM slave
    // Word-wide only: no byte enables, no bursts
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Bus data phase activity, one level per processor clock
    // Each line idles low; far-side agents raise it per active clock
    input wire logic self_drives_data,
    input wire logic self_samples_data,
    input wire logic unsampled_bus_data,
    input wire logic busy_self_drive,
    input wire logic busy_for_self_sample,
    input wire logic busy_not_self_sampled,
    // Queue allocation report
    // One pulse per new entry, with its attributes beside it
    input wire logic alloc_valid,
    input wire logic [4:0] alloc_req_type,
    input wire logic alloc_is_read,
    input wire logic alloc_is_write,
    input wire logic [4:0] alloc_mem_type,
    input wire logic alloc_by_self,
    input wire logic alloc_full_line,
    input wire logic alloc_single_chunk
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Software-visible registers first, then per-counter state
    logic [31:0] select_0; // bus_event_select_0
    logic [31:0] select_1; // bus_event_select_1
    logic [3:0] model_field; // Part model, steers allocation logic
    logic [7:0] cfg; // Enable and edge bits
    logic [31:0] count [NUM_COUNTERS]; // Event counters
    logic [NUM_COUNTERS-1:0] ev_prev; // Last event level for edge mode
    logic [NUM_COUNTERS-1:0] ev_now; // Event level this cycle
    // Next values, worked out by the register process
    logic [31:0] next_select_0;
    logic [31:0] next_select_1;
    logic [3:0] next_model_field;
    logic [7:0] next_cfg;
    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic wr_take; // Write takes effect this edge

    // ------------------------------------------------------------
    // Counter address decode
    // ------------------------------------------------------------
    // Shared by the read mux and the preload path, so the two can never
    // disagree on where a counter lives
    function automatic logic [7:0] count_addr(input int idx);
        count_addr = ADDR_COUNT_BASE + 8'(idx * ADDR_COUNT_STEP);
    endfunction : count_addr

    // ------------------------------------------------------------
    // Event evaluation for one selection register
    // ------------------------------------------------------------
    // Pure combinational: every counter calls it with its own selection
    // word, so adding a counter adds no new decode logic by hand.
    // Codes other than the two handled here give a level of zero, which
    // keeps a counter quiet rather than counting something undefined.
    function automatic logic event_level(
        // Selection word and part model
        input logic [31:0] sel,
        input logic [3:0] model,
        // Data-phase levels
        input logic d_drv,
        input logic d_own,
        input logic d_oth,
        input logic b_drv,
        input logic b_own,
        input logic b_oth,
        // Allocation report
        input logic a_val,
        input logic [4:0] a_req,
        input logic a_rd,
        input logic a_wr,
        input logic [4:0] a_mem,
        input logic a_self,
        input logic a_line,
        input logic a_chunk
    );
        // Partial results, one per term of the equations
        logic [15:0] m;
        logic [6:0] code;
        logic req_hit;
        logic rw_hit;
        logic mem_hit;
        logic src_hit;
        logic entry_ok;
        logic da;
        logic qa;
        // Split the selection word into code and mask
        m = sel[MASK_HI:MASK_LO];
        code = sel[CODE_HI:CODE_LO];
        // Own has priority so the two sampled kinds never both count
        // Drive and busy-drive are not exclusive with either of them
        da = (m[DA_SELF_DRIVES] & d_drv)
            | (m[DA_SELF_SAMPLES] & d_own)
            | (m[DA_UNSAMPLED] & d_oth & ~d_own)
            | (m[DA_BUSY_DRIVE] & b_drv)
            | (m[DA_BUSY_SELF] & b_own)
            | (m[DA_BUSY_OTHER] & b_oth & ~b_own);
        // Allocation terms, one per mask sub-group
        req_hit = (m[QA_REQ_HI:QA_REQ_LO] == a_req);
        rw_hit = (m[QA_ALL_READ] & a_rd) | (m[QA_ALL_WRITE] & a_wr);
        // Memory type ignored once a catch-all read or write is chosen
        if (m[QA_ALL_READ] | m[QA_ALL_WRITE]) begin
            mem_hit = 1'b1;
        end else begin
            mem_hit = |(m[QA_MEM_HI:QA_MEM_LO] & a_mem);
        end
        // Source agent: this processor, or any other agent
        src_hit = (m[QA_OWN] & a_self) | (m[QA_OTHER] & ~a_self);
        // Only whole lines or single chunks form a queue entry
        entry_ok = a_line | a_chunk;
        // No privilege input exists: user and OS requests both count
        // Newer parts AND all four groups; older ones OR the first three
        if (model >= MODEL_SPLIT) begin
            qa = req_hit & rw_hit & mem_hit & src_hit;
        end else begin
            qa = (req_hit | rw_hit | mem_hit) & src_hit;
        end
        // Nothing counts without an allocation pulse
        qa = qa & a_val & entry_ok;
        // The event code picks which of the two levels counts
        if (code == CODE_DATA_ACTIVITY) begin
            event_level = da;
        end else if (code == CODE_QUEUE_ALLOC) begin
            event_level = qa;
        end else begin
            event_level = 1'b0;
        end
    endfunction : event_level

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then answer
    // ------------------------------------------------------------
    // Every access costs two clocks. The fixed wait lets read data come
    // from a register, so readdata is a flop output and never a long
    // mux path; back-to-back throughput is traded for that.
    // A write lands only on the edge where the master sees waitrequest low.
    assign wr_take = write & ~waitrequest;

    // Next register values and read data
    always_comb begin
        // Hold registers and read data unless the bus says otherwise; waitrequest defaults high
        next_select_0 = select_0;
        next_select_1 = select_1;
        next_model_field = model_field;
        next_cfg = cfg;
        next_readdata = readdata;
        next_waitrequest = 1'b1;
        // Release on the cycle after a request is seen
        if ((read | write) & waitrequest) begin
            next_waitrequest = 1'b0;
        end
        // Read data is latched together with waitrequest dropping
        // Readdata holds its value between reads; software sees no glitch
        if (read & waitrequest) begin
            if (address == ADDR_SELECT_0) begin
                next_readdata = select_0;
            end else if (address == ADDR_SELECT_1) begin
                next_readdata = select_1;
            end else if (address == ADDR_MODEL) begin
                next_readdata = {28'h0000000, model_field};
            end else if (address == ADDR_CONFIG) begin
                next_readdata = {24'h000000, cfg};
            end else if (address == count_addr(0)) begin
                next_readdata = count[0];
            end else if (address == count_addr(1)) begin
                next_readdata = count[1];
            end else if (address == count_addr(2)) begin
                next_readdata = count[2];
            end else if (address == count_addr(3)) begin
                next_readdata = count[3];
            end else begin
                next_readdata = WORD_ZERO; // Unmapped reads zero
            end
        end
        // Register writes land on the accepting edge
        // Counter preloads are taken in the counter process, not here
        // Only the low bits of model and config words are kept
        if (wr_take) begin
            if (address == ADDR_SELECT_0) begin
                next_select_0 = writedata;
            end else if (address == ADDR_SELECT_1) begin
                next_select_1 = writedata;
            end else if (address == ADDR_MODEL) begin
                next_model_field = writedata[3:0];
            end else if (address == ADDR_CONFIG) begin
                next_cfg = writedata[7:0];
            end
        end
    end

    // Register control state
    // Model field comes out of reset at its default, waitrequest high, the rest at zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            select_0 <= WORD_ZERO;
            select_1 <= WORD_ZERO;
            model_field <= MODEL_RESET;
            cfg <= 8'h00;
            readdata <= WORD_ZERO;
            waitrequest <= 1'b1;
        end else begin
            select_0 <= next_select_0;
            select_1 <= next_select_1;
            model_field <= next_model_field;
            cfg <= next_cfg;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
        end
    end

    // ------------------------------------------------------------
    // Counters: two per selection register
    // ------------------------------------------------------------
    // Each counter is 32 bits and wraps silently; software must read it
    // often enough to see a wrap. The enable bit gates counting only,
    // so a disabled counter can still be preloaded.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
            logic [31:0] next_count;
            logic inc;
            logic [7:0] cnt_addr;
            // Preload address of this counter
            assign cnt_addr = count_addr(gi);
            // Counters 0,1 see select 0; counters 2,3 see select 1
            // The split is fixed in hardware; software cannot reroute it
            assign ev_now[gi] = event_level((gi < SELECT_SPAN) ? select_0 : select_1,
                model_field, self_drives_data, self_samples_data,
                unsampled_bus_data, busy_self_drive, busy_for_self_sample,
                busy_not_self_sampled, alloc_valid, alloc_req_type,
                alloc_is_read, alloc_is_write, alloc_mem_type,
                alloc_by_self, alloc_full_line, alloc_single_chunk);
            // Edge mode keeps one multi-cycle burst from counting twice
            // Level mode adds one for every clock the event stands
            always_comb begin
                inc = cfg[CFG_EN_LO + gi] & ev_now[gi]
                    & (~cfg[CFG_EDGE_LO + gi] | ~ev_prev[gi]);
                // Hold by default
                next_count = count[gi];
                // A preload and an event in one cycle: the preload wins, the
                // event of that cycle is lost, which software must allow for
                if (wr_take && address == cnt_addr) begin
                    next_count = writedata; // Software preload wins
                end else if (inc) begin
                    next_count = count[gi] + 32'h00000001;
                end
            end
            // Counter and edge history
            // Edge history runs even while disabled, so enabling mid-burst
            // waits for the next rising level instead of counting at once
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    count[gi] <= WORD_ZERO;
                    ev_prev[gi] <= 1'b0;
                end else begin
                    count[gi] <= next_count;
                    ev_prev[gi] <= ev_now[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Programming notes
    // ------------------------------------------------------------
    // Write the selection word first, then preload, then enable: a
    // counter enabled under a stale selection counts the old event.
    // Data-phase lines last two or four clocks, so level mode counts
    // clocks and edge mode counts transfers.
    // A new model field applies from the edge after its write; an
    // allocation before that edge is judged by the old equation.
    // Reads of unmapped words return zero and writes to them are
    // dropped, so a probe of the map is harmless.

endmodule : bdp_event_counter

//--- verilog/bdp_pkg.sv
package bdp_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SELECT_0 = 8'h00; // First bus selection register
    localparam logic [7:0] ADDR_SELECT_1 = 8'h04; // Second bus selection register
    localparam logic [7:0] ADDR_MODEL = 8'h08; // Model field of this part
    localparam logic [7:0] ADDR_CONFIG = 8'h0C; // Enable and edge bits per counter
    localparam logic [7:0] ADDR_COUNT_BASE = 8'h10; // Counter 0, then one word each
    localparam int NUM_COUNTERS = 4;
    localparam int ADDR_COUNT_STEP = 4; // Byte stride between counters
    localparam int SELECT_SPAN = 2; // Counters fed by each selection register

    // ------------------------------------------------------------
    // Selection register fields
    // ------------------------------------------------------------
    localparam int CODE_HI = 31; // Event code field top bit
    localparam int CODE_LO = 25; // Event code field bottom bit
    localparam int MASK_HI = 24; // Sub-event mask field top bit
    localparam int MASK_LO = 9; // Sub-event mask field bottom bit
    localparam logic [6:0] CODE_DATA_ACTIVITY = 7'h17; // Bus data activity
    localparam logic [6:0] CODE_QUEUE_ALLOC = 7'h03; // Queue allocation

    // Data activity mask bits
    localparam int DA_SELF_DRIVES = 0;
    localparam int DA_SELF_SAMPLES = 1;
    localparam int DA_UNSAMPLED = 2;
    localparam int DA_BUSY_DRIVE = 3;
    localparam int DA_BUSY_SELF = 4;
    localparam int DA_BUSY_OTHER = 5;

    // Queue allocation mask bits
    localparam int QA_REQ_LO = 0; // Request type field, bits 0..4
    localparam int QA_REQ_HI = 4;
    localparam int QA_ALL_READ = 5;
    localparam int QA_ALL_WRITE = 6;
    localparam int QA_MEM_LO = 7; // Memory type bits 7..11 (UC WC WT WP WB)
    localparam int QA_MEM_HI = 11;
    localparam int QA_OWN = 13;
    localparam int QA_OTHER = 14;

    // ------------------------------------------------------------
    // Model and config fields
    // ------------------------------------------------------------
    localparam logic [3:0] MODEL_SPLIT = 4'h2; // Models at or above use AND form
    localparam logic [3:0] MODEL_RESET = 4'h2; // Default model field
    localparam int CFG_EDGE_LO = 0; // Edge trigger bits 3..0
    localparam int CFG_EN_LO = 4; // Enable bits 7..4
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

endpackage : bdp_pkg

//--- dv/bdp_event_counter_asserts.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Register bus timing and read data checks
// ------------------------------------------------------------
module bdp_asserts
    import bdp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // A taken request is answered at the very next edge
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    // The answer lasts one cycle only
    a_wait_once: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    // No answer without a request
    a_wait_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("answer without request");
    // Slave still waits at the first edge out of reset
    a_wait_reset: assert property ($rose(rstn) |-> waitrequest)
        else $error("waitrequest low right after reset");
    // Unmapped reads give zero
    a_unmapped_zero: assert property (read && !waitrequest && address >= 8'h20 |-> readdata == 0)
        else $error("unmapped read not zero");
    // Model word has only four live bits
    a_model_width: assert property (read && !waitrequest && address == ADDR_MODEL
        |-> readdata[31:4] == 28'h0) else $error("model word upper bits set");
    // Read data moves only after a read has been seen waiting
    a_data_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("readdata moved without a read");
endmodule : bdp_asserts

bind bdp_event_counter bdp_asserts bdp_asserts_i (.mclk(mclk), .rstn(rstn),
    .address(address), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest));

//--- dv/bdp_bus_model.sv
`timescale 1ns/1ps

// Far-side bus agents: hold chosen data-phase lines for a burst
module bdp_bus_model (
    // Clock
    input wire logic mclk,
    // Burst request from the bench
    input wire logic go,
    input wire logic [5:0] lines,
    input wire logic [2:0] len,
    // Data-phase activity levels
    output logic [5:0] act
);
    logic [2:0] cnt = 3'h0; // Cycles left in the burst
    logic [5:0] held = 6'h00; // Lines of this burst

    // Two cycles for partial, four for full line transfers
    always_ff @(posedge mclk) begin
        if (go) begin
            cnt <= len;
            held <= lines;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    // Lines idle low between bursts
    assign act = (cnt != 3'h0) ? held : 6'h00;
endmodule : bdp_bus_model

//--- dv/bus_data_phase_event_counter_bench.sv
`timescale 1ns/1ps

module bus_data_phase_event_counter_bench;
    import bdp_pkg::*;
    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic mclk = 0, rstn = 0, read = 0, write = 0, go = 0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, pre;
    logic waitrequest;
    logic [5:0] act, plines = 6'h00;
    logic [2:0] plen = 3'h0;
    logic [15:0] av = 16'h0; // valid, req, rd, wr, mem, self, line, chunk
    logic [39:0] exp_q[$], ce; // Address and expected word
    logic [15:0] atab[9] = '{16'h8686, 16'h8A86, 16'h860E, 16'h8685, 16'h8684,
        16'h8682, 16'h8586, 16'h8A86, 16'h8A82};
    logic [0:8] ebits = 9'b101100010; // Expected allocation counts
    int error_cnt = 0, checks = 0, cyc = 0, n;

    bdp_event_counter bdp_event_counter_i (.mclk(mclk), .rstn(rstn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .self_drives_data(act[0]), .self_samples_data(act[1]),
        .unsampled_bus_data(act[2]), .busy_self_drive(act[3]),
        .busy_for_self_sample(act[4]), .busy_not_self_sampled(act[5]),
        .alloc_valid(av[15]), .alloc_req_type(av[14:10]), .alloc_is_read(av[9]),
        .alloc_is_write(av[8]), .alloc_mem_type(av[7:3]), .alloc_by_self(av[2]),
        .alloc_full_line(av[1]), .alloc_single_chunk(av[0]));
    bdp_bus_model bdp_bus_model_i (.mclk(mclk), .go(go), .lines(plines), .len(plen),
        .act(act));

    initial begin
        forever #20 mclk = ~mclk;
    end
    // Hang guard: whole run needs well under this
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // Monitor: read data is taken at the edge where waitrequest is seen low
    always @(posedge mclk) begin
        if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
            ce = exp_q.pop_front();
            checks++;
            if (readdata !== ce[31:0]) begin
                error_cnt++;
                $display("CHECK FAILED readdata @%h exp %h got %h", ce[39:32], ce[31:0], readdata);
            end
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= d;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task chk(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({a, e});
        bus(1'b1, a, WORD_ZERO);
    endtask : chk
    // Select mask m on counter 0, burst lines l for k cycles, expect e more
    task dt(input logic [15:0] m, input logic [5:0] l, input int k, input int e);
        bus(1'b0, ADDR_SELECT_0, {CODE_DATA_ACTIVITY, m, 9'h000});
        pre = $urandom;
        bus(1'b0, ADDR_COUNT_BASE, pre);
        bus(1'b0, ADDR_COUNT_BASE + 8'h08, WORD_ZERO);
        @(posedge mclk);
        go <= 1'b1;
        plines <= l;
        plen <= 3'(k);
        @(posedge mclk);
        go <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(ADDR_COUNT_BASE, pre + 32'(e));
        chk(ADDR_COUNT_BASE + 8'h08, WORD_ZERO);
    endtask : dt
    task close_out;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        void'($urandom(92633));
        chk(ADDR_MODEL, {28'h0, MODEL_RESET});
        chk(ADDR_SELECT_0, WORD_ZERO);
        bus(1'b0, 8'h40, $urandom);
        chk(8'h40, WORD_ZERO);
        $display("test reset_map done");
        bus(1'b0, ADDR_CONFIG, 32'h00000050); // Counters 0 and 2 on, level mode
        for (int i = 0; i < 6; i++) begin
            n = ($urandom % 2) ? 4 : 2;
            dt(16'(1 << i), 6'(1 << i), n, n);
        end
        dt(16'h0004, 6'b000110, 4, 0);
        dt(16'h0006, 6'b000110, 4, 4);
        dt(16'h0009, 6'b001001, 2, 2);
        bus(1'b0, ADDR_CONFIG, 32'h00000051);
        dt(16'h0001, 6'b000001, 4, 1);
        bus(1'b0, ADDR_CONFIG, 32'h00000050);
        $display("test data_activity done");
        bus(1'b0, ADDR_SELECT_0, {CODE_QUEUE_ALLOC, 16'h2821, 9'h000});
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, ADDR_MODEL, (i < 7) ? 32'h2 : 32'h1);
            bus(1'b0, ADDR_COUNT_BASE, WORD_ZERO);
            @(posedge mclk);
            av <= atab[i];
            @(posedge mclk);
            av <= 16'h0;
            @(posedge mclk);
            chk(ADDR_COUNT_BASE, {31'h0, ebits[i]});
        end
        $display("test queue_alloc done");
        close_out();
    end
endmodule : bus_data_phase_event_counter_bench
